/* File: hdl/qr_pkg.sv */
// Constants shared by the turn-on sequencer and its helper modules.
// Assumes a single 50 MHz control clock; feedback levels arrive as millivolt codes.
package qr_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int BLANK_MIN_NS = 4160;
   localparam int BLANK_MAX_NS = 16000;
   localparam int FORCE_NS = 2700;
   localparam int START_FORCE_NS = 23000;
   localparam int TON_DELAY_NS = 197;
   localparam int FREQ_CAP_KHZ = 240;
   localparam logic [11:0] BLANK_MIN_CYC = 12'((BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] BLANK_MAX_CYC = 12'((BLANK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] FORCE_CYC = 12'((FORCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] START_FORCE_CYC = 12'((START_FORCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] DELAY_CYC = 12'((TON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] MIN_PERIOD_CYC =
      12'((1000000 + FREQ_CAP_KHZ * CLK_PERIOD_NS - 1) / (FREQ_CAP_KHZ * CLK_PERIOD_NS));
   localparam logic [11:0] FB_BURST_MV = 12'h2BC;
   localparam logic [11:0] FB_FOLD_MV = 12'h47E;
   localparam logic [11:0] FF_LO_MV = 12'h320;
   localparam logic [11:0] FF_HI_MV = 12'h4B0;
   localparam logic [11:0] FF_W_LO = 12'h014;
   localparam logic [11:0] FF_W_HI = 12'h064;
   localparam logic [11:0] TB_STEP_CYC = 12'h005;
   localparam logic [11:0] PEAK_BASE = 12'h800;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [3:0] VALLEY_MAX = 4'hF;
   localparam logic [11:0] CNT_MAX = 12'hFFF;
   localparam int SYNC_W = 7;

   typedef enum logic [2:0] {
      S_OFF = 3'b000,
      S_ON = 3'b001,
      S_BLANK = 3'b011,
      S_HUNT = 3'b010,
      S_DELAY = 3'b110
   } seq_state_t;
endpackage

/* File: hdl/qr_sync2.sv */
// Two-flop synchroniser for a group of independent comparator levels.
// Assumes each bit is a level that stays put for several clock periods.
module qr_sync2 #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

/* File: hdl/qr_lin_interp.sv */
// Clamped straight-line map from a feedback code to a result between two end values.
// Assumes x_hi is above x_lo; purely combinational, so the caller registers the result.
module qr_lin_interp (
   input wire logic [11:0] x,
   input wire logic [11:0] x_lo,
   input wire logic [11:0] x_hi,
   input wire logic [11:0] y_at_lo,
   input wire logic [11:0] y_at_hi,
   output logic [11:0] y
);
   logic signed [25:0] span_y;
   logic signed [25:0] prod;
   logic signed [25:0] quot;

   always_comb begin
      span_y = $signed({14'h0000, y_at_hi}) - $signed({14'h0000, y_at_lo});
      prod = span_y * $signed({14'h0000, x - x_lo});
      quot = prod / $signed({14'h0000, x_hi - x_lo});
      if (x <= x_lo) begin
         y = y_at_lo;
      end else if (x >= x_hi) begin
         y = y_at_hi;
      end else begin
         y = 12'($signed({14'h0000, y_at_lo}) + quot);
      end
   end
endmodule

/* File: hdl/qr_turn_on_sequencer.sv */
// Turn-on sequencer for a quasi-resonant flyback switch: arming, blanking, valley skip and lock,
// forced turn-on, burst stop/restart and load-weighted line compensation.
// Assumes comparator levels come from pins; feedback and current codes come from ADCs on this clock.
// Functional notes
// - Turn switch on at an armed falling crossing below the trigger level.
// - Arm only after sense rises above arming level; unarmed crossings never trigger.
// - After turn-on, blank trigger logic against leakage ringing crossings.
// - Switching period never shorter than the 240 kHz cap.
// - Blanking window longest at burst threshold, shortest at foldback, linear between.
// - Crossing after window expiry turns switch on after a short delay.
// - Without valley lock, crossings inside the window ignored; first one after expiry acts.
// - Without valid crossing, force turn-on a fixed time after window ends.
// - Starter fires cycles while sense cannot arm; then lock to demagnetization.
// - Valley lock holds the skipped valley count constant against bus ripple.
// - Valley lock off below 1.3 V, back on only at 1.43 V.
// - Feedback 60 mV below burst threshold stops switching, lowers consumption.
// - Burst stop ends once feedback climbs back to burst threshold.
// - Sample sense pin current each on-time, mirror into line compensation.
// - Line compensation lowers peak current set point as input rises.
// - Compensation weight full above 1.2 V, one fifth below 0.8 V, linear between.
// - Tuning pin optionally extends the blanking window with line voltage.
// - Default window about 4.16 us at high feedback, 16 us at burst.
// - Default delay from valid crossing to turn-on about 197 ns.
module qr_turn_on_sequencer (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic zero_cross_arm,
   input wire logic zero_cross_low,
   input wire logic peak_reached,
   input wire logic burst_stop_cmp,
   input wire logic burst_resume_cmp,
   input wire logic lock_low_cmp,
   input wire logic lock_high_cmp,
   input wire logic blank_tune_disable,
   input wire logic [11:0] feedback_level,
   input wire logic [7:0] blank_tune_pin,
   input wire logic [9:0] zero_cross_sense,
   output logic gate_drive_r,
   output logic quiet_mode_r,
   output logic valley_lock_on_r,
   output logic [9:0] line_comp_current_r,
   output logic [11:0] peak_setpoint_r
);
   import qr_pkg::*;

   logic rst_meta_r;
   logic rst_sync_n_r;
   logic [SYNC_W-1:0] pins_s;
   logic arm_s, low_s, peak_s, stop_s, resume_s, llow_s, lhigh_s;
   logic tb_dis_s;
   logic arm_q_r, low_q_r;
   logic arm_rise, low_fall;
   logic armed_r;
   logic seen_arm_r;
   logic [1:0] strap_cnt_r;
   logic tb_on_r;
   logic [11:0] blank_fb;
   logic [11:0] weight_fb;
   logic [11:0] blank_len_r;
   logic [11:0] weight_r;
   logic [11:0] per_cnt_r;
   logic [11:0] tmr_r;
   logic [3:0] valley_cnt_r;
   logic [3:0] lock_n_r;
   logic lock_valid_r;
   logic [9:0] sense_r;
   seq_state_t state_r, state_nxt;
   logic valid_trig, lock_go, force_go, period_ok, turn_on, unlocked_trig;
   logic [16:0] comp_prod;

   function automatic logic [11:0] sat_inc(input logic [11:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + 12'h001;
   endfunction

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   qr_sync2 #(.W(SYNC_W)) u_pin_sync (
      .clock(clock),
      .rst_n(rst_sync_n_r),
      .async_in({zero_cross_arm, zero_cross_low, peak_reached, burst_stop_cmp, burst_resume_cmp,
                 lock_low_cmp, lock_high_cmp}),
      .sync_out(pins_s)
   );
   assign {arm_s, low_s, peak_s, stop_s, resume_s, llow_s, lhigh_s} = pins_s;

   qr_sync2 #(.W(1)) u_strap_sync (
      .clock(clock),
      .rst_n(rst_sync_n_r),
      .async_in(blank_tune_disable),
      .sync_out(tb_dis_s)
   );

   qr_lin_interp u_blank_map (
      .x(feedback_level),
      .x_lo(FB_BURST_MV),
      .x_hi(FB_FOLD_MV),
      .y_at_lo(BLANK_MAX_CYC),
      .y_at_hi(BLANK_MIN_CYC),
      .y(blank_fb)
   );

   qr_lin_interp u_weight_map (
      .x(feedback_level),
      .x_lo(FF_LO_MV),
      .x_hi(FF_HI_MV),
      .y_at_lo(FF_W_LO),
      .y_at_hi(FF_W_HI),
      .y(weight_fb)
   );

   // Edge detectors read only the synchronised copies.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         arm_q_r <= 1'b0;
         low_q_r <= 1'b0;
      end else begin
         arm_q_r <= arm_s;
         low_q_r <= low_s;
      end
   end
   assign arm_rise = arm_s & ~arm_q_r;
   assign low_fall = low_s & ~low_q_r;

   // The tuning strap is caught once after release and held until the next reset.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         strap_cnt_r <= 2'h0;
         tb_on_r <= 1'b0;
      end else if (strap_cnt_r != STRAP_WAIT) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == STRAP_WAIT - 2'h1) begin
            tb_on_r <= ~tb_dis_s;
         end
      end
   end

   // The window is frozen at turn-on so a moving feedback code cannot shorten a running window.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         blank_len_r <= BLANK_MIN_CYC;
         weight_r <= FF_W_HI;
      end else begin
         weight_r <= weight_fb;
         if (turn_on) begin
            blank_len_r <= blank_fb + (tb_on_r ? 12'(blank_tune_pin) * TB_STEP_CYC : 12'h000);
         end
      end
   end

   // A new arming edge in the turn-on cycle wins over the clear.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         armed_r <= 1'b0;
         seen_arm_r <= 1'b0;
      end else begin
         if (turn_on) begin
            armed_r <= 1'b0;
         end
         if (arm_rise) begin
            armed_r <= 1'b1;
            seen_arm_r <= 1'b1;
         end else if (turn_on && state_r == S_HUNT && !valid_trig) begin
            seen_arm_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         quiet_mode_r <= 1'b0;
         valley_lock_on_r <= 1'b0;
      end else begin
         if (stop_s) begin
            quiet_mode_r <= 1'b1;
         end else if (resume_s) begin
            quiet_mode_r <= 1'b0;
         end
         if (llow_s) begin
            valley_lock_on_r <= 1'b0;
         end else if (lhigh_s) begin
            valley_lock_on_r <= 1'b1;
         end
      end
   end

   assign period_ok = per_cnt_r >= MIN_PERIOD_CYC;
   assign valid_trig = low_fall & armed_r;
   assign lock_go = valley_lock_on_r & lock_valid_r & valid_trig & (valley_cnt_r + 4'h1 >= lock_n_r);
   assign unlocked_trig = valid_trig & ~(valley_lock_on_r & lock_valid_r);
   assign force_go = tmr_r >= (seen_arm_r ? FORCE_CYC : START_FORCE_CYC);
   assign turn_on = (state_nxt == S_ON) && (state_r != S_ON);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_OFF: begin
            if (!quiet_mode_r) begin
               state_nxt = S_HUNT;
            end
         end
         S_ON: begin
            if (peak_s) begin
               state_nxt = S_BLANK;
            end
         end
         S_BLANK: begin
            if (lock_go) begin
               state_nxt = S_DELAY;
            end else if (per_cnt_r >= blank_len_r) begin
               state_nxt = S_HUNT;
            end
         end
         S_HUNT: begin
            if (unlocked_trig || lock_go) begin
               state_nxt = S_DELAY;
            end else if (force_go && period_ok) begin
               state_nxt = S_ON;
            end
         end
         S_DELAY: begin
            if (tmr_r >= DELAY_CYC - 12'h001 && period_ok) begin
               state_nxt = S_ON;
            end
         end
         default: state_nxt = S_OFF;
      endcase
      if (quiet_mode_r) begin
         state_nxt = S_OFF;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         state_r <= S_OFF;
         gate_drive_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         gate_drive_r <= state_nxt == S_ON;
      end
   end

   // Period counter runs from turn-on; state timer restarts on every state change.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         per_cnt_r <= CNT_MAX;
         tmr_r <= 12'h000;
      end else begin
         per_cnt_r <= turn_on ? 12'h000 : sat_inc(per_cnt_r);
         tmr_r <= (state_nxt != state_r) ? 12'h000 : sat_inc(tmr_r);
      end
   end

   // Ringing valleys are counted so the chosen valley can be repeated while the lock holds.
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         valley_cnt_r <= 4'h0;
         lock_n_r <= 4'h0;
         lock_valid_r <= 1'b0;
      end else begin
         if (turn_on) begin
            valley_cnt_r <= 4'h0;
         end else if (low_fall && valley_cnt_r != VALLEY_MAX) begin
            valley_cnt_r <= valley_cnt_r + 4'h1;
         end
         if (!valley_lock_on_r || quiet_mode_r || (state_r == S_HUNT && force_go && period_ok)) begin
            lock_valid_r <= 1'b0;
         end else if (state_r == S_HUNT && unlocked_trig) begin
            lock_valid_r <= 1'b1;
            lock_n_r <= (valley_cnt_r == VALLEY_MAX) ? VALLEY_MAX : valley_cnt_r + 4'h1;
         end
      end
   end

   assign comp_prod = 17'(sense_r) * weight_r[6:0];

   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         sense_r <= 10'h000;
         line_comp_current_r <= 10'h000;
         peak_setpoint_r <= PEAK_BASE;
      end else begin
         if (state_r == S_ON) begin
            sense_r <= zero_cross_sense;
         end
         line_comp_current_r <= 10'(comp_prod / 17'h00064);
         peak_setpoint_r <= PEAK_BASE - 12'(line_comp_current_r);
      end
   end

   logic [11:0] gap_r;
   always_ff @(posedge clock or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         gap_r <= CNT_MAX;
      end else begin
         gap_r <= (gate_drive_r && !$past(gate_drive_r)) ? 12'h001 : sat_inc(gap_r);
      end
   end

   freq_cap_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      $rose(gate_drive_r) |-> gap_r >= MIN_PERIOD_CYC - 12'h001)
      else $error("turn-on came sooner than the frequency cap allows");
   arm_needed_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (state_r == S_HUNT && state_nxt == S_DELAY) |-> armed_r)
      else $error("trigger accepted without arming");
   blank_ignore_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (state_r == S_BLANK && per_cnt_r < blank_len_r && !lock_go) |=> state_r != S_DELAY)
      else $error("crossing inside the blanking window acted");
   arm_clear_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (turn_on && !arm_rise) |=> !armed_r)
      else $error("arming survived a turn-on");
   delay_len_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (state_r == S_HUNT && state_nxt == S_DELAY && !quiet_mode_r) |=> !gate_drive_r [*8] ##1 !gate_drive_r)
      else $error("turn-on delay shorter than its default");
   burst_stop_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      quiet_mode_r |=> !gate_drive_r)
      else $error("switch driven during burst stop");
   burst_resume_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (quiet_mode_r && resume_s && !stop_s) |=> !quiet_mode_r)
      else $error("burst stop did not end at the restart level");
   lock_hyst_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (!valley_lock_on_r && !lhigh_s) |=> !valley_lock_on_r)
      else $error("valley lock came back without the upper level");
   force_on_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      (state_r == S_HUNT && seen_arm_r && tmr_r == FORCE_CYC && period_ok && !quiet_mode_r
       && !valid_trig) |=> gate_drive_r)
      else $error("forced turn-on missed after the window");
   blank_range_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
      blank_fb >= BLANK_MIN_CYC && blank_fb <= BLANK_MAX_CYC)
      else $error("blanking length outside its span");

   qr_cycle_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
      state_r == S_DELAY ##1 state_r == S_ON);
   forced_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
      state_r == S_HUNT && state_nxt == S_ON);
   locked_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
      state_r == S_BLANK && lock_go);
   burst_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
      $fell(quiet_mode_r));
endmodule

/* File: dv/qr_comparators.sv */
// Behavioural model of the sense and feedback comparators that face the sequencer.
// Assumes the bench hands it the sense and feedback levels in millivolts on the control clock.
module qr_comparators (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] sense_mv,
   input wire logic [11:0] fb_mv,
   input wire logic gate_on,
   output logic arm,
   output logic low,
   output logic peak,
   output logic stop,
   output logic resume,
   output logic lock_low,
   output logic lock_high
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] on_cnt_r;

   // The peak comparator trips a fixed 20 cycles into each on-time, so every pulse is the same length.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt_r <= 5'h00;
      end else if (!gate_on) begin
         on_cnt_r <= 5'h00;
      end else if (on_cnt_r != 5'h1F) begin
         on_cnt_r <= on_cnt_r + 5'h01;
      end
   end

   // All decisions are plain levels changing on the clock, as the sequencer expects.
   assign peak = (on_cnt_r >= 5'h14);
   assign arm = (sense_mv > 12'h06E);
   assign low = (sense_mv < 12'h03C);
   assign stop = (fb_mv <= 12'h280);
   assign resume = (fb_mv >= 12'h2BC);
   assign lock_low = (fb_mv < 12'h514);
   assign lock_high = (fb_mv >= 12'h596);
endmodule

/* File: dv/qr_turn_on_sequencer_test.sv */
// Self-checking bench for the turn-on sequencer, with a comparator model on its far side.
// Assumes a 50 MHz clock; every wait is bounded and ends the run when it runs out.
module qr_turn_on_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_n, strap_off, gate_drive_r, quiet_mode_r, valley_lock_on_r;
   logic arm, low, peak, stop, resume, lock_low, lock_high;
   logic [11:0] sense_mv, feedback_level, peak_setpoint_r;
   logic [7:0] tune_code;
   logic [9:0] sense_code, line_comp_current_r;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   qr_comparators u_qr_comparators (.clock(clock), .rst_n(rst_n), .sense_mv(sense_mv), .fb_mv(feedback_level),
      .gate_on(gate_drive_r), .arm(arm), .low(low), .peak(peak), .stop(stop), .resume(resume),
      .lock_low(lock_low), .lock_high(lock_high));

   qr_turn_on_sequencer u_qr_turn_on_sequencer (.clock(clock), .rst_n(rst_n), .zero_cross_arm(arm),
      .zero_cross_low(low), .peak_reached(peak), .burst_stop_cmp(stop), .burst_resume_cmp(resume),
      .lock_low_cmp(lock_low), .lock_high_cmp(lock_high), .blank_tune_disable(strap_off),
      .feedback_level(feedback_level), .blank_tune_pin(tune_code), .zero_cross_sense(sense_code),
      .gate_drive_r(gate_drive_r), .quiet_mode_r(quiet_mode_r), .valley_lock_on_r(valley_lock_on_r),
      .line_comp_current_r(line_comp_current_r), .peak_setpoint_r(peak_setpoint_r));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(posedge clock) cyc <= cyc + 1;

   task automatic give_verdict();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
         num_errors++;
      end
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge clock);
         #1;
      end
   endtask

   task automatic set_in(input logic [11:0] s, input logic [11:0] f);
      @(posedge clock);
      sense_mv <= s;
      feedback_level <= f;
      #1;
   endtask

   // Waits for the next rising edge of the gate and returns the cycle stamp at which it was seen.
   task automatic wait_on(input int lim, output int t);
      int n;
      n = 0;
      while (gate_drive_r !== 1'b0 && n < lim) begin
         tick(1);
         n++;
      end
      while (gate_drive_r !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      t = cyc;
      if (n >= lim) begin
         num_errors++;
         give_verdict();
      end
   endtask

   task automatic do_reset(input logic off, input logic [7:0] code);
      @(posedge clock);
      rst_n <= 1'b0;
      strap_off <= off;
      tune_code <= code;
      tick(1);
      @(posedge clock);
      rst_n <= 1'b1;
      tick(6);
      chk(peak_setpoint_r, 32'h800);
      chk(gate_drive_r, 1'b0);
   endtask

   // Without arming, only the starter may turn the switch on, and a bare crossing is ignored.
   task automatic starter_case();
      int t0, t1;
      set_in(12'h050, 12'h47E);
      wait_on(1500, t0);
      tick(250);
      set_in(12'h01E, 12'h47E);
      wait_on(2000, t1);
      chk(t1 - t0 > 1000, 1'b1);
      set_in(12'h050, 12'h47E);
   endtask

   // Crossings inside the window are ignored; an armed one after it fires after the short delay.
   task automatic trigger_case();
      int t0, tc, t1;
      wait_on(2000, t0);
      tick(30);
      set_in(12'h0C8, 12'h47E);
      tick(4);
      set_in(12'h01E, 12'h47E);
      set_in(12'h050, 12'h47E);
      tick(200);
      set_in(12'h0C8, 12'h47E);
      tick(4);
      set_in(12'h01E, 12'h47E);
      tc = cyc;
      wait_on(400, t1);
      chk(t1 > tc, 1'b1);
      chk(t1 - tc >= 11 && t1 - tc <= 15, 1'b1);
      chk(t1 - t0 >= 209, 1'b1);
      set_in(12'h050, 12'h47E);
   endtask

   // An arm rise with no crossing leads to a forced turn-on a fixed time after the window.
   task automatic forced_case(input logic [11:0] fb, input int exp);
      int t0, t1;
      set_in(12'h050, fb);
      wait_on(2500, t0);
      wait_on(2500, t0);
      tick(30);
      set_in(12'h0C8, fb);
      tick(4);
      set_in(12'h050, fb);
      wait_on(2500, t1);
      chk(t1 - t0 >= exp - 2 && t1 - t0 <= exp + 8, 1'b1);
   endtask

   task automatic burst_case();
      int hi, t;
      hi = 0;
      set_in(12'h050, 12'h276);
      tick(6);
      chk(quiet_mode_r, 1'b1);
      for (int i = 0; i < 1500; i++) begin
         tick(1);
         hi += int'(gate_drive_r === 1'b1);
      end
      chk(hi, 0);
      set_in(12'h050, 12'h2BC);
      tick(6);
      chk(quiet_mode_r, 1'b0);
      wait_on(2500, t);
   endtask

   // Walks the feedback up and down across both lock levels.
   task automatic lock_case();
      logic [11:0] fbs [5] = '{12'h5AA, 12'h546, 12'h4E2, 12'h546, 12'h596};
      logic exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 5; i++) begin
         set_in(12'h050, fbs[i]);
         tick(6);
         chk(valley_lock_on_r, exp[i]);
      end
   endtask

   // One arm rise followed by a single falling crossing of the sense level.
   task automatic ring(input logic [11:0] f);
      set_in(12'h0C8, f);
      tick(4);
      set_in(12'h01E, f);
      set_in(12'h050, f);
   endtask

   // With the lock on, the recorded valley is taken again inside the next window, held back only by the cap.
   task automatic valley_case();
      int t0, t1, t2;
      set_in(12'h050, 12'h5AA);
      wait_on(2500, t0);
      tick(30);
      ring(12'h5AA);
      tick(200);
      ring(12'h5AA);
      wait_on(400, t1);
      chk(t1 - t0 >= 209, 1'b1);
      tick(30);
      ring(12'h5AA);
      tick(50);
      ring(12'h5AA);
      wait_on(400, t2);
      chk(t2 - t1 >= 209 && t2 - t1 <= 215, 1'b1);
   endtask

   // The on-time sample is scaled by the load weight and taken off the peak set point.
   task automatic comp_case();
      logic [11:0] fbs [3] = '{12'h320, 12'h3E8, 12'h4B0};
      logic [9:0] exp [3] = '{10'h014, 10'h03C, 10'h064};
      int t;
      for (int i = 0; i < 3; i++) begin
         set_in(12'h050, fbs[i]);
         @(posedge clock);
         sense_code <= 10'h064;
         #1;
         wait_on(2500, t);
         wait_on(2500, t);
         tick(25);
         chk(line_comp_current_r, exp[i]);
         chk(peak_setpoint_r, 12'h800 - {2'h0, exp[i]});
      end
   endtask

   initial begin
      rst_n = 1'b0;
      strap_off = 1'b1;
      tune_code = 8'h00;
      sense_mv = 12'h050;
      feedback_level = 12'h47E;
      sense_code = 10'h000;
      do_reset(1'b1, 8'h00);
      starter_case();
      trigger_case();
      forced_case(12'h47E, 343);
      forced_case(12'h2BC, 935);
      burst_case();
      lock_case();
      valley_case();
      comp_case();
      // A fresh reset is needed because the strap is caught only once after release.
      do_reset(1'b0, 8'h14);
      forced_case(12'h47E, 443);
      give_verdict();
   end
endmodule
